// [hw/rsc_pkg.sv]
// Constants and types for the reset and stop-mode controller.
// Assumes a single 200 MHz system clock and an APB3 register port.
//
// Notes on behaviour
// - Reset pin low four cycles resets, except while recovery runs.
// - Stay in reset while pin held low.
// - Leave reset on third edge after pin release.
// - Pin reset sets pin cause flag.
// - Reset pin driven open-drain during the delay of any reset.
// - Internal reset drives pin until delay ends.
// - Debugger request resets all but debug unit.
// - Debugger request bit clears during its reset.
// - Debugger reset sets power-on cause flag.
// - Stop instruction enters stop mode.
// - Recovery holds CPU 66 or 5000 cycles.
// - Recovery changes cause, oscillator and interrupt status registers.
// - Recovery enables and selects fast oscillator.
// - Stop halts oscillators, releases crystal pins.
// - Stop halts system clock, CPU and counter.
// - Watchdog oscillator and logic may keep running.
// - Brownout runs in stop only if optioned.
package rsc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] RSC_CAUSE_OFS = 12'h000;
  localparam logic [11:0] RSC_OSC_OFS = 12'h004;
  localparam logic [11:0] RSC_CTRL_OFS = 12'h008;
  localparam logic [11:0] RSC_IRQ_OFS = 12'h00c;
  localparam logic [11:0] RSC_MASK_OFS = 12'h010;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Cause register.
  localparam int RSC_CAUSE_POR = 7;
  localparam int RSC_CAUSE_PIN = 6;
  localparam int RSC_CAUSE_WDT = 5;
  localparam int RSC_CAUSE_STOP = 4;
  localparam int RSC_CAUSE_BOR = 3;
  // Oscillator control register.
  localparam int RSC_OSC_FAST_EN = 7;
  localparam int RSC_OSC_XTAL_EN = 6;
  localparam int RSC_OSC_WDOG_EN = 5;
  localparam int RSC_OSC_SEL_LSB = 0;
  localparam logic [1:0] RSC_SEL_FAST = 2'h0;
  // Control register.
  localparam int RSC_CTRL_DBG_RST = 0;
  localparam int RSC_CTRL_RPIN_DRV = 1;
  localparam int RSC_CTRL_WDT_EN = 2;
  // Interrupt status bits.
  localparam int RSC_IRQ_RESET = 0;
  localparam int RSC_IRQ_WAKE = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RSC_CAUSE_RST = 8'h80;
  localparam logic [7:0] RSC_OSC_RST = 8'ha0;
  localparam logic [7:0] RSC_CTRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RSC_CLK_MHZ = 200;
  localparam int RSC_PIN_MIN_CYC = 4;
  localparam int RSC_PIN_CNT_W = 3;
  localparam int RSC_REC_FAST_CYC = 66;
  localparam int RSC_REC_XTAL_CYC = 5000;
  localparam int RSC_RST_DELAY_NS = 1000;
  localparam int RSC_RST_DELAY_CYC = (RSC_RST_DELAY_NS * RSC_CLK_MHZ + 999) / 1000;
  localparam int RSC_CNT_W = 16;

  typedef enum logic [2:0] {
    RSC_RUN,
    RSC_RESET,
    RSC_STOP,
    RSC_RECOVER
  } rsc_state_t;

endpackage

// [hw/rsc_ctrl.sv]
// Reset and stop-mode controller: pin reset, reset indication, debugger
// reset, cause flags, stop entry and recovery, with an APB3 register port.
// Assumes internal reset sources and the stop instruction arrive as
// single-cycle or level signals on pclk; the reset pin is asynchronous.
`timescale 1ns/1ps
module rsc_ctrl #(
  parameter int unsigned REC_XTAL_CYC = rsc_pkg::RSC_REC_XTAL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic por_event,
  input wire logic brownout_event,
  input wire logic watchdog_event,
  input wire logic stop_instr,
  input wire logic wake_event,
  input wire logic brownout_stop_option,
  output logic sys_reset_n,
  output logic cpu_reset_n,
  output logic sys_clk_en,
  output logic fast_osc_en,
  output logic xtal_osc_en,
  output logic xtal_pins_en,
  output logic wdog_osc_en,
  output logic wdog_logic_en,
  output logic brownout_en,
  output logic periph_en,
  output logic [1:0] clk_sel,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic [rsc_pkg::RSC_PIN_CNT_W-1:0] low_cnt;
    rsc_pkg::rsc_state_t st;
    logic [rsc_pkg::RSC_CNT_W-1:0] cnt;
    logic pin_cause;
    logic dbg_cause;
    logic int_cause;
    logic xtal_hold;
    logic [7:0] cause;
    logic [7:0] osc;
    logic [7:0] ctrl;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rpin_oe;
    logic sys_rst_n;
    logic cpu_rst_n;
    logic clk_en;
    logic irq;
  } rsc_regs_t;

  rsc_regs_t q;
  rsc_regs_t d;

  logic wr;
  logic rd;
  logic pin_low;
  logic int_evt;
  logic [rsc_pkg::RSC_CNT_W-1:0] rec_cyc;

  // Narrow a cycle figure to the counter width.
  function automatic logic [rsc_pkg::RSC_CNT_W-1:0] cyc(input int unsigned n);
    cyc = rsc_pkg::RSC_CNT_W'(n);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    // Only the second flop of the synchroniser is looked at.
    d.pin_s1 = reset_pin_in;
    d.pin_s2 = q.pin_s1;
    // Count low samples; four in a row is a guaranteed reset request.
    if (q.pin_s2)
    begin
      d.low_cnt = '0;
    end
    else if (q.low_cnt != rsc_pkg::RSC_PIN_CNT_W'(rsc_pkg::RSC_PIN_MIN_CYC))
    begin
      d.low_cnt = q.low_cnt + 1'b1;
    end
    pin_low = !q.pin_s2 &&
      (q.low_cnt == rsc_pkg::RSC_PIN_CNT_W'(rsc_pkg::RSC_PIN_MIN_CYC - 1) ||
       q.low_cnt == rsc_pkg::RSC_PIN_CNT_W'(rsc_pkg::RSC_PIN_MIN_CYC));
    int_evt = por_event || brownout_event ||
      (watchdog_event && q.ctrl[rsc_pkg::RSC_CTRL_WDT_EN]);
    // The crystal enable is cleared on stop entry, so its earlier value is kept.
    rec_cyc = q.xtal_hold ? cyc(REC_XTAL_CYC) :
      cyc(rsc_pkg::RSC_REC_FAST_CYC);
    d.pready = psel && !penable;
    d.pslverr = 1'b0;

    // Reset, stop and recovery sequencer.
    unique case (q.st)
      rsc_pkg::RSC_RUN:
      begin
        if (pin_low || int_evt || q.ctrl[rsc_pkg::RSC_CTRL_DBG_RST])
        begin
          d.st = rsc_pkg::RSC_RESET;
          d.cnt = cyc(rsc_pkg::RSC_RST_DELAY_CYC);
          d.pin_cause = pin_low;
          d.int_cause = int_evt;
          d.dbg_cause = q.ctrl[rsc_pkg::RSC_CTRL_DBG_RST];
          d.sys_rst_n = 1'b0;
          d.cpu_rst_n = 1'b0;
          d.irq_st[rsc_pkg::RSC_IRQ_RESET] = 1'b1;
        end
        else if (stop_instr)
        begin
          d.st = rsc_pkg::RSC_STOP;
          d.xtal_hold = q.osc[rsc_pkg::RSC_OSC_XTAL_EN];
          d.clk_en = 1'b0;
          d.osc[rsc_pkg::RSC_OSC_FAST_EN] = 1'b0;
          d.osc[rsc_pkg::RSC_OSC_XTAL_EN] = 1'b0;
        end
      end
      rsc_pkg::RSC_RESET:
      begin
        if (q.cnt != '0)
        begin
          d.cnt = q.cnt - 1'b1;
        end
        d.ctrl[rsc_pkg::RSC_CTRL_DBG_RST] = 1'b0;
        // The pin reads low from our own drive here, so it is not a cause.
        if (int_evt)
        begin
          d.int_cause = 1'b1;
        end
        // Release on the first edge after the synchronised pin reads high and the delay ends.
        if (q.cnt == '0 && q.pin_s2 && !int_evt)
        begin
          d.st = rsc_pkg::RSC_RUN;
          d.sys_rst_n = 1'b1;
          d.cpu_rst_n = 1'b1;
          d.clk_en = 1'b1;
          d.cause = '0;
          d.cause[rsc_pkg::RSC_CAUSE_PIN] = q.pin_cause;
          d.cause[rsc_pkg::RSC_CAUSE_POR] = q.dbg_cause || por_event ||
            (q.int_cause && !q.pin_cause);
          d.osc = rsc_pkg::RSC_OSC_RST;
          d.ctrl = rsc_pkg::RSC_CTRL_RST;
          d.pin_cause = 1'b0;
          d.dbg_cause = 1'b0;
          d.int_cause = 1'b0;
        end
      end
      rsc_pkg::RSC_STOP:
      begin
        // Only recovery or a reset leaves stop.
        if (pin_low || int_evt)
        begin
          d.st = rsc_pkg::RSC_RESET;
          d.cnt = cyc(rsc_pkg::RSC_RST_DELAY_CYC);
          d.pin_cause = pin_low;
          d.int_cause = int_evt;
          d.sys_rst_n = 1'b0;
          d.cpu_rst_n = 1'b0;
        end
        else if (wake_event)
        begin
          d.st = rsc_pkg::RSC_RECOVER;
          d.cnt = rec_cyc;
          d.clk_en = 1'b1;
          d.cpu_rst_n = 1'b0;
          d.osc[rsc_pkg::RSC_OSC_FAST_EN] = 1'b1;
          d.osc[rsc_pkg::RSC_OSC_SEL_LSB +: 2] = rsc_pkg::RSC_SEL_FAST;
          d.cause = '0;
          d.cause[rsc_pkg::RSC_CAUSE_STOP] = 1'b1;
        end
      end
      rsc_pkg::RSC_RECOVER:
      begin
        if (q.cnt != '0)
        begin
          d.cnt = q.cnt - 1'b1;
        end
        else
        begin
          d.st = rsc_pkg::RSC_RUN;
          d.cpu_rst_n = 1'b1;
          d.irq_st[rsc_pkg::RSC_IRQ_WAKE] = 1'b1;
        end
      end
      default:
      begin
        d.st = rsc_pkg::RSC_RESET;
      end
    endcase

    // Register writes; cause flags are read-only, status is write-one-clear.
    if (wr)
    begin
      unique case (paddr)
        rsc_pkg::RSC_OSC_OFS: d.osc = pwdata[7:0];
        rsc_pkg::RSC_CTRL_OFS: d.ctrl = pwdata[7:0];
        rsc_pkg::RSC_IRQ_OFS: d.irq_st = q.irq_st & ~pwdata[1:0];
        rsc_pkg::RSC_MASK_OFS: d.irq_mask = pwdata[1:0];
        default: d.pslverr = 1'b0;
      endcase
      // A new event in the same cycle as its clear still sets the bit.
      if (q.st == rsc_pkg::RSC_RUN && d.st == rsc_pkg::RSC_RESET)
      begin
        d.irq_st[rsc_pkg::RSC_IRQ_RESET] = 1'b1;
      end
      if (q.st == rsc_pkg::RSC_RECOVER && d.st == rsc_pkg::RSC_RUN)
      begin
        d.irq_st[rsc_pkg::RSC_IRQ_WAKE] = 1'b1;
      end
    end

    // Read data is captured in the setup phase and held for the access.
    if (rd)
    begin
      unique case (paddr)
        rsc_pkg::RSC_CAUSE_OFS: d.prdata = {24'h000000, q.cause};
        rsc_pkg::RSC_OSC_OFS: d.prdata = {24'h000000, q.osc};
        rsc_pkg::RSC_CTRL_OFS: d.prdata = {24'h000000, q.ctrl};
        rsc_pkg::RSC_IRQ_OFS: d.prdata = {30'h00000000, q.irq_st};
        rsc_pkg::RSC_MASK_OFS: d.prdata = {30'h00000000, q.irq_mask};
        default: d.prdata = 32'h00000000;
      endcase
    end
    d.pslverr = psel && !penable &&
      !(paddr inside {rsc_pkg::RSC_CAUSE_OFS, rsc_pkg::RSC_OSC_OFS,
        rsc_pkg::RSC_CTRL_OFS, rsc_pkg::RSC_IRQ_OFS, rsc_pkg::RSC_MASK_OFS});

    // Open-drain indicator: pulled low while the reset delay runs or on request.
    // It is let go once the delay ends, otherwise our own drive would hold
    // the sensed pin low and reset could never be left.
    d.rpin_oe = (d.st == rsc_pkg::RSC_RESET && d.cnt != '0) ||
      d.ctrl[rsc_pkg::RSC_CTRL_RPIN_DRV];
    d.irq = |(d.irq_st & d.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Power-up lands in reset so the pin is pulled low from the start.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.pin_s1 <= 1'b1;
      q.pin_s2 <= 1'b1;
      q.st <= rsc_pkg::RSC_RESET;
      q.cnt <= rsc_pkg::RSC_CNT_W'(rsc_pkg::RSC_RST_DELAY_CYC);
      q.dbg_cause <= 1'b1;
      q.cause <= rsc_pkg::RSC_CAUSE_RST;
      q.osc <= rsc_pkg::RSC_OSC_RST;
      q.ctrl <= rsc_pkg::RSC_CTRL_RST;
      q.rpin_oe <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs from flops, except constant reset_pin_out and brownout_en, which ORs in brownout_stop_option
  // ----------------------------------------------------------------
  // In stop only the watchdog and the optioned brownout keep running.
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = q.rpin_oe;
  assign sys_reset_n = q.sys_rst_n;
  assign cpu_reset_n = q.cpu_rst_n;
  assign sys_clk_en = q.clk_en;
  assign fast_osc_en = q.osc[rsc_pkg::RSC_OSC_FAST_EN];
  assign xtal_osc_en = q.osc[rsc_pkg::RSC_OSC_XTAL_EN];
  assign xtal_pins_en = q.osc[rsc_pkg::RSC_OSC_XTAL_EN];
  assign wdog_osc_en = q.osc[rsc_pkg::RSC_OSC_WDOG_EN];
  assign wdog_logic_en = q.ctrl[rsc_pkg::RSC_CTRL_WDT_EN];
  assign brownout_en = q.clk_en || brownout_stop_option;
  assign periph_en = q.clk_en;
  assign clk_sel = q.osc[rsc_pkg::RSC_OSC_SEL_LSB +: 2];
  assign irq = q.irq;

endmodule

// [verification/rsc_ctrl_properties.sv]
// Port checker for the reset and stop-mode controller.
// Assumes a bind onto rsc_ctrl; reset_pin_in is the wired pin level.
`timescale 1ns/1ps
module rsc_ctrl_props #(
  parameter int unsigned REC_XTAL_CYC = rsc_pkg::RSC_REC_XTAL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic stop_instr,
  input wire logic brownout_stop_option,
  input wire logic sys_reset_n,
  input wire logic cpu_reset_n,
  input wire logic sys_clk_en,
  input wire logic fast_osc_en,
  input wire logic xtal_osc_en,
  input wire logic xtal_pins_en,
  input wire logic brownout_en,
  input wire logic periph_en,
  input wire logic [1:0] clk_sel
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // One clock domain, so one default clock and disable serve all.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pin_reset_a: assert property ((!reset_pin_in) [*8] |-> !sys_reset_n)
    else $error("pin low but system running");
  pin_release_a: assert property ($rose(reset_pin_in) && !sys_reset_n |-> ##[1:4] sys_reset_n)
    else $error("late exit from reset");
  oe_reset_a: assert property ($fell(sys_reset_n) |-> reset_pin_oe [*8])
    else $error("pin not driven in reset");
  open_drain_a: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("pin driven high");
  stop_entry_a: assert property (sys_reset_n && cpu_reset_n && sys_clk_en && stop_instr
    |=> !(sys_clk_en || fast_osc_en || xtal_osc_en || xtal_pins_en))
    else $error("stop not entered");
  stop_idle_a: assert property (!sys_clk_en ##1 !sys_clk_en
    |-> !periph_en && brownout_en == brownout_stop_option)
    else $error("peripherals awake in stop");
  wake_clock_a: assert property ($rose(sys_clk_en) && $past(sys_reset_n)
    |-> !cpu_reset_n ##[0:2] (fast_osc_en && clk_sel == 2'h0))
    else $error("bad recovery clocking");
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no access phase answer");
endmodule

// [verification/rsc_line_model.sv]
// Reset line shared with other parts, with its pull-up.
// Assumes the device only ever sinks the line.
`timescale 1ns/1ps
module rsc_line_model (
  input wire logic drive_oe,
  input wire logic drive_val,
  input wire logic ext_low,
  output logic line
);
  // Wired-AND: any party sinking wins, else the pull-up.
  assign line = !((drive_oe && !drive_val) || ext_low);
endmodule

// [verification/testbench.sv]
// Directed bench for the reset and stop-mode controller.
// Assumes the line model gives the reset pin level.
`timescale 1ns/1ps
module testbench;
  localparam int unsigned REC = 20;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic por_event = 1'h0, brownout_event = 1'h0, watchdog_event = 1'h0, ext_low = 1'h0;
  logic stop_instr = 1'h0, wake_event = 1'h0, brownout_stop_option = 1'h1, a, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, reset_pin_in, reset_pin_out, reset_pin_oe, sys_reset_n;
  logic cpu_reset_n, sys_clk_en, fast_osc_en, xtal_osc_en, xtal_pins_en, wdog_osc_en;
  logic wdog_logic_en, brownout_en, periph_en, irq;
  logic [1:0] clk_sel;
  int err_count = 0, comparisons = 0, n;

  rsc_ctrl #(.REC_XTAL_CYC(REC)) rsc_ctrl_inst (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .reset_pin_in, .reset_pin_out,
    .reset_pin_oe, .por_event, .brownout_event, .watchdog_event, .stop_instr, .wake_event,
    .brownout_stop_option, .sys_reset_n, .cpu_reset_n, .sys_clk_en, .fast_osc_en,
    .xtal_osc_en, .xtal_pins_en, .wdog_osc_en, .wdog_logic_en, .brownout_en, .periph_en,
    .clk_sel, .irq);
  rsc_line_model rsc_line_model_inst (.drive_oe(reset_pin_oe), .drive_val(reset_pin_out),
    .ext_low, .line(reset_pin_in));

  // 200 MHz clock.
  always #2.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x)
    begin
      err_count++;
      $display("unexpected %s exp %h seen %h", nm, x, s);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] x);
    apb(1'h0, ad, 32'h0);
    chk("read", r, x);
  endtask

  // Bounded wait for the system reset output to reach v.
  task automatic till(input logic v, input int lim);
    n = 0;
    while (sys_reset_n !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk("sysrst", 32'(sys_reset_n), 32'(v));
  endtask

  // One-cycle pulse: 0 stop, 1 wake, 2 watchdog; then k more edges.
  task automatic pulse_wait(input int which, input int k);
    if (which == 0)
      stop_instr <= 1'h1;
    else if (which == 1)
      wake_event <= 1'h1;
    else
      watchdog_event <= 1'h1;
    @(posedge pclk);
    stop_instr <= 1'h0;
    wake_event <= 1'h0;
    watchdog_event <= 1'h0;
    repeat (k) @(posedge pclk);
  endtask

  // Stop, then wake; hold length depends on the crystal enable.
  task automatic stop_wake(input logic [7:0] osc, input int hold);
    apb(1'h1, 12'h004, 32'(osc));
    apb(1'h1, 12'h008, 32'h4);
    apb(1'h1, 12'h00c, 32'h3);
    pulse_wait(0, 2);
    chk("stop", 32'({sys_clk_en, fast_osc_en, xtal_osc_en, xtal_pins_en}), 32'h0);
    chk("keep", 32'({wdog_osc_en, wdog_logic_en, brownout_en, periph_en}), 32'he);
    pulse_wait(1, 1);
    n = 0;
    while (cpu_reset_n !== 1'h1 && n < 6000)
    begin
      @(posedge pclk);
      n++;
    end
    chk("hold", 32'(n >= hold && n <= hold + 6), 32'h1);
    rd(12'h000, 32'h10);
    rd(12'h008, 32'h4);
    apb(1'h0, 12'h004, 32'h0);
    chk("osc", r & 32'h83, 32'h80);
    rd(12'h00c, 32'h2);
    apb(1'h1, 12'h010, 32'h0);
    @(posedge pclk);
    a = irq;
    apb(1'h1, 12'h010, 32'h3);
    @(posedge pclk);
    chk("mask", 32'(a ^ irq), 32'h1);
    apb(1'h1, 12'h00c, 32'h3);
    @(posedge pclk);
    chk("clear", 32'(irq), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    till(1'h1, 400);
    rd(12'h000, 32'h80);
    rd(12'h004, 32'ha0);
    apb(1'h1, 12'h000, 32'hff);
    rd(12'h000, 32'h80);
    rd(12'h020, 32'h0);
    chk("slverr", 32'(e), 32'h1);
    ext_low <= 1'h1;
    repeat (250) @(posedge pclk);
    chk("held", 32'(sys_reset_n), 32'h0);
    ext_low <= 1'h0;
    till(1'h1, 9);
    apb(1'h0, 12'h000, 32'h0);
    chk("pin", 32'(r[6]), 32'h1);
    apb(1'h1, 12'h008, 32'h1);
    till(1'h0, 20);
    till(1'h1, 400);
    rd(12'h008, 32'h0);
    apb(1'h0, 12'h000, 32'h0);
    chk("por", 32'(r[7]), 32'h1);
    apb(1'h1, 12'h008, 32'h4);
    pulse_wait(2, 6);
    chk("drive", 32'(reset_pin_in), 32'h0);
    till(1'h1, 400);
    chk("line", 32'(reset_pin_in), 32'h1);
    stop_wake(8'h21, 66);
    stop_wake(8'h61, REC);
    close_out();
  end

  // Guard against a hang.
  initial
  begin
    #100000;
    err_count++;
    close_out();
  end
endmodule

bind rsc_ctrl rsc_ctrl_props #(.REC_XTAL_CYC(REC_XTAL_CYC)) rsc_ctrl_props_inst (.pclk,
  .presetn, .psel, .penable, .pready, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
  .stop_instr, .brownout_stop_option, .sys_reset_n, .cpu_reset_n, .sys_clk_en,
  .fast_osc_en, .xtal_osc_en, .xtal_pins_en, .brownout_en, .periph_en, .clk_sel);
